// [core/ixl_cfg.svh]
`ifndef IXL_CFG_SVH
`define IXL_CFG_SVH
// instruction word layout
`define IXL_IW_W        10
`define IXL_NIB_W       4
// index-increment opcode, full word
`define IXL_INY_CODE    10'h013
// accumulator load: top six bits 000111
`define IXL_LA_HI_MSB   9
`define IXL_LA_HI_LSB   4
`define IXL_LA_HI_CODE  6'h07
// index-pair load: top two bits 11
`define IXL_LXY_HI_MSB  9
`define IXL_LXY_HI_LSB  8
`define IXL_LXY_HI_CODE 2'h3
`define IXL_LXY_X_MSB   7
`define IXL_LXY_X_LSB   4
`define IXL_LXY_Y_MSB   3
`define IXL_LXY_Y_LSB   0
// increment step and wrap value
`define IXL_Y_STEP      4'h1
`define IXL_NIB_ZERO    4'h0
`define IXL_RST_NIB     4'h0
`endif

// [core/ixl_decode.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ixl_cfg.svh"
// pure opcode classifier for the three handled instructions
module ixl_decode
  import ixl_pkg::*;
(
  input  wire ixl_pkg::ixl_word_t i_word,
  output ixl_pkg::ixl_op_e        o_op,
  output ixl_pkg::ixl_nib_t       o_imm_hi,
  output ixl_pkg::ixl_nib_t       o_imm_lo
);
  // exact match first, then prefix classes
  always_comb begin
    o_op = IXL_OP_OTHER;
    if (i_word == `IXL_INY_CODE) begin
      o_op = IXL_OP_INY;
    end else if (i_word[`IXL_LA_HI_MSB:`IXL_LA_HI_LSB] == `IXL_LA_HI_CODE) begin
      o_op = IXL_OP_LA;
    end else if (i_word[`IXL_LXY_HI_MSB:`IXL_LXY_HI_LSB] == `IXL_LXY_HI_CODE) begin
      o_op = IXL_OP_LXY;
    end
  end
  // x field and y / n field
  assign o_imm_hi = i_word[`IXL_LXY_X_MSB:`IXL_LXY_X_LSB];
  assign o_imm_lo = i_word[`IXL_LXY_Y_MSB:`IXL_LXY_Y_LSB];
endmodule
`default_nettype wire

// [core/ixl_exec.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ixl_cfg.svh"
// Overview of operation
// - index-increment adds one to Y and stores result in Y.
// - skip next instruction when incremented Y wraps to zero.
// - accumulator load puts 4-bit immediate into A in one cycle.
// - index-pair load is top bits 11, X field next, Y field lowest.
// - index-pair load writes X and Y immediates in the same cycle.
// - in a run of accumulator loads or of index-pair loads only the first can execute; a skipped first word leaves none executed.
module ixl_exec
  import ixl_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_valid,
  input  wire ixl_pkg::ixl_word_t i_word,
  input  wire logic              i_skip,
  input  wire logic              i_carry_flag,
  output logic                   o_handled,
  output logic                   o_skipped,
  output logic                   o_skip_next,
  output ixl_pkg::ixl_nib_t      o_acc,
  output ixl_pkg::ixl_nib_t      o_x,
  output ixl_pkg::ixl_nib_t      o_y,
  output logic                   o_carry_flag
);
  import ixl_pkg::*;

  ixl_op_e  op;
  ixl_nib_t imm_hi;
  ixl_nib_t imm_lo;
  ixl_nib_t acc_reg, acc_next;
  ixl_nib_t x_reg, x_next;
  ixl_nib_t y_reg, y_next;
  ixl_nib_t y_inc;
  ixl_op_e  prev_reg, prev_next;
  logic     skipn_reg, skipn_next;
  logic     run_skip;

  ixl_decode u_decode (
    .i_word   (i_word),
    .o_op     (op),
    .o_imm_hi (imm_hi),
    .o_imm_lo (imm_lo)
  );

  // slices come from the layout macros; refuse a package that disagrees with them
  if (($bits(ixl_word_t) != `IXL_IW_W) || ($bits(ixl_nib_t) != `IXL_NIB_W)) begin : g_layout_chk
    $error("instruction word or nibble width does not match the layout");
  end

  assign y_inc = y_reg + `IXL_Y_STEP;
  // a load right after the same load is treated as skipped
  assign run_skip = ((op == IXL_OP_LA) && (prev_reg == IXL_OP_LA))
                 || ((op == IXL_OP_LXY) && (prev_reg == IXL_OP_LXY));

  // next-state: one instruction per valid cycle
  always_comb begin
    acc_next   = acc_reg;
    x_next     = x_reg;
    y_next     = y_reg;
    prev_next  = prev_reg;
    skipn_next = skipn_reg;
    if (i_valid) begin
      // run tracking follows every fetched word, skipped or not
      prev_next  = op;
      skipn_next = 1'b0;
      if (!i_skip && !run_skip) begin
        unique case (op)
          IXL_OP_INY: begin
            y_next     = y_inc;
            skipn_next = (y_inc == `IXL_NIB_ZERO);
          end
          IXL_OP_LA: begin
            acc_next = imm_lo;
          end
          IXL_OP_LXY: begin
            x_next = imm_hi;
            y_next = imm_lo;
          end
          IXL_OP_OTHER: begin
          end
        endcase
      end
    end
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg   <= `IXL_RST_NIB;
      x_reg     <= `IXL_RST_NIB;
      y_reg     <= `IXL_RST_NIB;
      prev_reg  <= IXL_OP_OTHER;
      skipn_reg <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      x_reg     <= x_next;
      y_reg     <= y_next;
      prev_reg  <= prev_next;
      skipn_reg <= skipn_next;
    end
  end

  assign o_acc        = acc_reg;
  assign o_x          = x_reg;
  assign o_y          = y_reg;
  assign o_skip_next  = skipn_reg;
  assign o_handled    = i_valid && (op != IXL_OP_OTHER);
  assign o_skipped    = i_valid && (i_skip || run_skip);
  assign o_carry_flag = i_carry_flag;

  property p_iny_inc;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && op == IXL_OP_INY) |=> (o_y == $past(y_reg) + `IXL_Y_STEP);
  endproperty
  a_iny_inc: assert property (p_iny_inc) else $error("y not incremented");
  property p_iny_skip;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && op == IXL_OP_INY) |=> (o_skip_next == (o_y == `IXL_NIB_ZERO));
  endproperty
  a_iny_skip: assert property (p_iny_skip) else $error("skip after wrap wrong");
  property p_la_load;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && !run_skip && op == IXL_OP_LA) |=> (o_acc == $past(imm_lo));
  endproperty
  a_la_load: assert property (p_la_load) else $error("acc not loaded");
  property p_la_run;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && op == IXL_OP_LA && prev_reg == IXL_OP_LA) |=> $stable(o_acc);
  endproperty
  a_la_run: assert property (p_la_run) else $error("second acc load executed");
  property p_lxy_dec;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_word[`IXL_LXY_HI_MSB:`IXL_LXY_HI_LSB] == `IXL_LXY_HI_CODE) |-> (op == IXL_OP_LXY);
  endproperty
  a_lxy_dec: assert property (p_lxy_dec) else $error("pair load not decoded");
  property p_lxy_load;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && !run_skip && op == IXL_OP_LXY)
        |=> (o_x == $past(imm_hi)) && (o_y == $past(imm_lo));
  endproperty
  a_lxy_load: assert property (p_lxy_load) else $error("x or y not loaded");
  property p_lxy_run;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && op == IXL_OP_LXY && prev_reg == IXL_OP_LXY) |=> ($stable(o_x) && $stable(o_y));
  endproperty
  a_lxy_run: assert property (p_lxy_run) else $error("second pair load executed");
  property p_carry;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_carry_flag == i_carry_flag;
  endproperty
  a_carry: assert property (p_carry) else $error("carry altered");
  property p_skip_once;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_skip_next && i_valid) |=> !o_skip_next;
  endproperty
  a_skip_once: assert property (p_skip_once) else $error("skip held too long");

  // side effects: each op writes only its own registers
  property p_iny_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && op == IXL_OP_INY) |=> ($stable(o_x) && $stable(o_acc));
  endproperty
  a_iny_keep: assert property (p_iny_keep) else $error("increment touched x or acc");
  property p_la_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && !run_skip && op == IXL_OP_LA) |=> ($stable(o_x) && $stable(o_y));
  endproperty
  a_la_keep: assert property (p_la_keep) else $error("acc load touched x or y");
  property p_lxy_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && !i_skip && !run_skip && op == IXL_OP_LXY) |=> $stable(o_acc);
  endproperty
  a_lxy_keep: assert property (p_lxy_keep) else $error("pair load touched acc");
  // a refused word changes none of acc, x and y and is reported as skipped
  property p_skip_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && i_skip) |=> ($stable(o_acc) && $stable(o_x) && $stable(o_y));
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skipped word changed a register");
  property p_skip_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && i_skip) |-> o_skipped;
  endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skipped word not flagged");
  // without a word nothing moves, the pending skip request included
  property p_idle_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_valid |=> ($stable(o_acc) && $stable(o_x) && $stable(o_y)
                    && $stable(o_skip_next));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved without a word");
  // repeats of a load are flagged skipped in the same cycle
  property p_la_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && op == IXL_OP_LA && prev_reg == IXL_OP_LA) |-> o_skipped;
  endproperty
  a_la_flag: assert property (p_la_flag) else $error("repeated acc load not flagged");
  property p_lxy_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && op == IXL_OP_LXY && prev_reg == IXL_OP_LXY) |-> o_skipped;
  endproperty
  a_lxy_flag: assert property (p_lxy_flag) else $error("repeated pair load not flagged");
  // the skip request only ever rises on a wrap to zero
  property p_skip_cause;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_skip_next) |-> (o_y == `IXL_NIB_ZERO);
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip raised without wrap");

  c_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_skip_next);
  c_la_run: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && op == IXL_OP_LA && prev_reg == IXL_OP_LA);
  c_lxy_run: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && op == IXL_OP_LXY && prev_reg == IXL_OP_LXY);
  c_skip_word: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_valid && i_skip);
  c_lxy_exec: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && !i_skip && !run_skip && op == IXL_OP_LXY);
endmodule
`default_nettype wire

// [core/ixl_pkg.sv]
package ixl_pkg;
  typedef logic [9:0] ixl_word_t;
  typedef logic [3:0] ixl_nib_t;
  typedef enum logic [1:0] {IXL_OP_OTHER, IXL_OP_INY, IXL_OP_LA, IXL_OP_LXY} ixl_op_e;
endpackage

// [verification/tb_index_and_immediate_load_ops.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_index_and_immediate_load_ops;
  import ixl_pkg::*;
  logic      i_clk, i_rst_n, i_valid, i_skip, i_carry_flag;
  ixl_word_t i_word;
  logic      o_handled, o_skipped, o_skip_next, o_carry_flag;
  ixl_nib_t  o_acc, o_x, o_y;
  int        n_mismatch = 0;
  int        n_tests = 0;
  int        cyc = 0;

  ixl_exec u_ixl_exec (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_word(i_word),
    .i_skip(i_skip), .i_carry_flag(i_carry_flag), .o_handled(o_handled), .o_skipped(o_skipped),
    .o_skip_next(o_skip_next), .o_acc(o_acc), .o_x(o_x), .o_y(o_y), .o_carry_flag(o_carry_flag));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // whole run needs well under a hundred cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp4(string nm, ixl_nib_t e, ixl_nib_t g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask

  // one word per falling edge; carry toggles with word bit 0 to catch any tampering
  task automatic op(ixl_word_t w, logic sk, logic e_skd, logic e_hnd = 1'b1);
    @(negedge i_clk);
    i_valid = 1'b1;
    i_word = w;
    i_skip = sk;
    i_carry_flag = w[0];
    #1;
    cmp1("handled", e_hnd, o_handled);
    cmp1("skipped", e_skd, o_skipped);
    cmp1("carry", w[0], o_carry_flag);
  endtask

  task automatic idle();
    @(negedge i_clk);
    i_valid = 1'b0;
    i_skip = 1'b0;
    #1;
  endtask

  task automatic t_lxy();
    op(10'h3AB, 1'b0, 1'b0);
    op(10'h3CD, 1'b0, 1'b1);
    idle();
    cmp4("x", 4'hA, o_x);
    cmp4("y", 4'hB, o_y);
    $display("test lxy done");
  endtask

  task automatic t_la();
    op(10'h07F, 1'b0, 1'b0);
    op(10'h075, 1'b0, 1'b1);
    idle();
    cmp4("acc", 4'hF, o_acc);
    op(10'h013, 1'b0, 1'b0);
    op(10'h070, 1'b1, 1'b1);
    op(10'h072, 1'b0, 1'b1);
    idle();
    cmp4("acc", 4'hF, o_acc);
    cmp4("y", 4'hC, o_y);
    $display("test la done");
  endtask

  task automatic t_iny();
    op(10'h3AF, 1'b0, 1'b0);
    op(10'h013, 1'b0, 1'b0);
    idle();
    cmp4("y", 4'h0, o_y);
    cmp4("x", 4'hA, o_x);
    cmp1("skip_next", 1'b1, o_skip_next);
    op(10'h013, 1'b1, 1'b1);
    idle();
    cmp4("y", 4'h0, o_y);
    cmp1("skip_next", 1'b0, o_skip_next);
    op(10'h013, 1'b0, 1'b0);
    idle();
    cmp4("y", 4'h1, o_y);
    cmp1("skip_next", 1'b0, o_skip_next);
    $display("test iny done");
  endtask

  // idle cycles keep a run, any other word breaks it
  task automatic t_break();
    op(10'h071, 1'b0, 1'b0);
    idle();
    idle();
    op(10'h072, 1'b0, 1'b1);
    op(10'h000, 1'b0, 1'b0, 1'b0);
    op(10'h073, 1'b0, 1'b0);
    idle();
    cmp4("acc", 4'h3, o_acc);
    op(10'h312, 1'b0, 1'b0);
    op(10'h074, 1'b0, 1'b0);
    op(10'h345, 1'b0, 1'b0);
    idle();
    cmp4("acc", 4'h4, o_acc);
    cmp4("x", 4'h4, o_x);
    cmp4("y", 4'h5, o_y);
    $display("test break done");
  endtask

  // mid-run reset clears registers and run history
  task automatic t_reset();
    op(10'h07A, 1'b0, 1'b0);
    idle();
    cmp4("acc", 4'hA, o_acc);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    #1;
    cmp4("acc", 4'h0, o_acc);
    cmp4("x", 4'h0, o_x);
    cmp4("y", 4'h0, o_y);
    cmp1("skip_next", 1'b0, o_skip_next);
    op(10'h075, 1'b0, 1'b0);
    idle();
    cmp4("acc", 4'h5, o_acc);
    $display("test reset done");
  endtask

  // reset held five cycles, released off the sampling edge
  initial begin
    i_rst_n = 1'b0;
    i_valid = 1'b0;
    i_skip = 1'b0;
    i_carry_flag = 1'b0;
    i_word = 10'h000;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    t_lxy();
    t_la();
    t_iny();
    t_break();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
